// *** rtl/aus_ctrl_status.sv ***
`timescale 1ns/100ps
// Overview of operation
// - minus flag follows result bit 35
// - equal flag set when result all zero
// - separate logical and mathematical overflow flags
// - flags updated by arithmetic and bit units
// - status holds one overflow bit per accumulator
// - status mirrors accumulator guard bits 35:32
// - policy 0: interrupt-register write resets generator outside service
// - policy 1: interrupt-register write never resets generator
// - squaring mode copies y high load into x
// - clear-inhibit bits disable low-half clearing
// - saturation-disable bits turn off accumulator saturation
// - alignment 00 plain, 01 quarter, 10 times four
// - alignment 11 shifts product left one
// - control register bits 15:9 read zero
// - reset clears the whole control register
// - data moves into accumulators leave flags alone
module aus_ctrl_status (
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SYS_RST,
  // Wishbone slave
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [31:0]           WB_DAT_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic                  WB_WE_I,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  // Operation results from the arithmetic and bit manipulation units
  input  wire aus_pkg::aus_op_t      DAU_OP,
  input  wire aus_pkg::aus_op_t      BMU_OP,
  input  wire logic [31:0]           PRODUCT,
  // Data moves into accumulators and operands
  input  wire aus_pkg::aus_move_t    ACC_MOVE,
  input  wire logic [15:0]           OPND_DATA,
  input  wire logic                  X_WR,
  input  wire logic                  Y_HI_WR,
  input  wire logic                  Y_LO_WR,
  // Generator reset control
  input  wire logic                  PI_WR,
  input  wire logic                  IN_ISR,
  output logic                       PSG_RESET,
  // Operand and accumulator views
  output logic      [15:0]           X_OPERAND,
  output logic      [31:0]           Y_OPERAND,
  output logic      [35:0]           ACC0_OUT,
  output logic      [35:0]           ACC1_OUT,
  // Interrupt
  output logic                       IRQ
);

  aus_pkg::aus_control_t ctl;
  logic [35:0]           acc [2];
  logic [35:0]           next_acc [2];
  logic [1:0]            acc_ovf;
  logic [1:0]            next_acc_ovf;
  logic [3:0]            flags;
  logic [3:0]            next_flags;
  logic [aus_pkg::IRQ_W-1:0] irq_stat;
  logic [aus_pkg::IRQ_W-1:0] irq_mask;
  logic [aus_pkg::IRQ_W-1:0] irq_evt;
  logic [15:0]           status_word;
  logic                  wb_hit;
  logic                  wr_status;
  logic                  wr_lo;
  logic                  wr_hi;
  logic                  psg_fire;
  aus_pkg::aus_op_t      op;

  function automatic logic [35:0] align_product(input logic [31:0] p,
                                                input aus_pkg::aus_align_t a);
    logic [35:0] p36;
    p36 = {{4{p[31]}}, p};
    unique case (a)
      aus_pkg::ALIGN_NONE: align_product = p36;
      aus_pkg::ALIGN_DIV4: align_product = {{2{p36[35]}}, p36[35:2]};
      aus_pkg::ALIGN_MUL4: align_product = {p36[33:0], 2'b00};
      aus_pkg::ALIGN_MUL2: align_product = {p36[34:0], 1'b0};
    endcase
  endfunction : align_product

  // An accumulator has overflowed when its guard bits disagree with bit 31.
  function automatic logic [35:0] saturate(input logic [35:0] v, input logic dis);
    if (!dis && !((&v[35:31]) || !(|v[35:31]))) begin
      saturate = v[35] ? aus_pkg::SAT_NEG : aus_pkg::SAT_POS;
    end else begin
      saturate = v;
    end
  endfunction : saturate

  // Bus decode; ack comes one cycle after the request and drops the next.
  assign wb_hit    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_lo     = wb_hit && WB_WE_I && WB_SEL_I[0];
  assign wr_hi     = wb_hit && WB_WE_I && WB_SEL_I[1];
  assign wr_status = (wr_lo || wr_hi) && (WB_ADR_I == aus_pkg::ADR_STATUS);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_hit;
    end
  end

  assign status_word = {flags, 2'b00,
                        acc_ovf[1], acc[1][35:32],
                        acc_ovf[0], acc[0][35:32]};

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (wb_hit && !WB_WE_I) begin
      unique case (WB_ADR_I)
        aus_pkg::ADR_STATUS:   WB_DAT_O <= {16'h0000, status_word};
        aus_pkg::ADR_CONTROL:  WB_DAT_O <= {23'h00_0000, ctl};
        aus_pkg::ADR_IRQ_STAT: WB_DAT_O <= {29'h0000_0000, irq_stat};
        aus_pkg::ADR_IRQ_MASK: WB_DAT_O <= {29'h0000_0000, irq_mask};
        default:               WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; bits above 8 are not stored, so they read zero.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctl <= aus_pkg::CTL_RESET;
    end else if (WB_ADR_I == aus_pkg::ADR_CONTROL) begin
      if (wr_lo) begin
        ctl[7:0] <= WB_DAT_I[7:0];
      end
      if (wr_hi) begin
        ctl[8] <= WB_DAT_I[8];
      end
    end
  end

  // The arithmetic unit has priority; if both units finish together, the bit unit result is dropped.
  always_comb begin
    op = DAU_OP.wr ? DAU_OP : BMU_OP;
    if (DAU_OP.wr && DAU_OP.use_product) begin
      op.value = align_product(PRODUCT, ctl.align);
    end
  end

  always_comb begin
    next_flags = flags;
    if (wr_status && wr_hi) begin
      next_flags = WB_DAT_I[15:12];
    end
    if (op.wr) begin
      next_flags[aus_pkg::ST_MINUS-12]    = op.value[35];
      next_flags[aus_pkg::ST_EQUAL-12]    = (op.value == 36'h0_0000_0000);
      next_flags[aus_pkg::ST_LOG_OVF-12]  = op.logical_overflow;
      next_flags[aus_pkg::ST_MATH_OVF-12] = op.math_overflow;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      flags <= 4'h0;
    end else begin
      flags <= next_flags;
    end
  end

  // Per accumulator: operation beats move, move beats a status write.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_acc[i]     = acc[i];
      next_acc_ovf[i] = acc_ovf[i];
      if (wr_status && wr_lo) begin
        next_acc[i][35:32] = (i == 1) ? WB_DAT_I[8:5] : WB_DAT_I[3:0];
        next_acc_ovf[i]    = (i == 1) ? WB_DAT_I[9] : WB_DAT_I[4];
      end
      if (ACC_MOVE.wr && (int'(ACC_MOVE.acc) == i)) begin
        if (ACC_MOVE.high) begin
          next_acc[i][35:16] = {{4{ACC_MOVE.data[15]}}, ACC_MOVE.data};
          if (!ctl.clear_inhibit_field[i]) begin
            next_acc[i][15:0] = 16'h0000;
          end
        end else begin
          next_acc[i][15:0] = ACC_MOVE.data;
        end
      end
      if (op.wr && (int'(op.acc) == i)) begin
        next_acc[i]     = op.value;
        next_acc_ovf[i] = op.math_overflow;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      acc[0]  <= 36'h0_0000_0000;
      acc[1]  <= 36'h0_0000_0000;
      acc_ovf <= 2'b00;
    end else begin
      acc[0]  <= next_acc[0];
      acc[1]  <= next_acc[1];
      acc_ovf <= next_acc_ovf;
    end
  end

  // Saturation is applied on the way out, so the stored value keeps its
  // guard bits and the status word still shows the true overflow.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ACC0_OUT <= 36'h0_0000_0000;
      ACC1_OUT <= 36'h0_0000_0000;
    end else begin
      ACC0_OUT <= saturate(acc[0], ctl.saturation_disable_field[0]);
      ACC1_OUT <= saturate(acc[1], ctl.saturation_disable_field[1]);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      X_OPERAND <= 16'h0000;
    end else if (Y_HI_WR && ctl.square_mode) begin
      X_OPERAND <= OPND_DATA;
    end else if (X_WR) begin
      X_OPERAND <= OPND_DATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      Y_OPERAND <= 32'h0000_0000;
    end else if (Y_HI_WR) begin
      Y_OPERAND[31:16] <= OPND_DATA;
      if (!ctl.clear_inhibit_field[aus_pkg::CLR_Y]) begin
        Y_OPERAND[15:0] <= 16'h0000;
      end
    end else if (Y_LO_WR) begin
      Y_OPERAND[15:0] <= OPND_DATA;
    end
  end

  assign psg_fire = PI_WR && !ctl.generator_reset_policy && !IN_ISR;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      PSG_RESET <= 1'b0;
    end else begin
      PSG_RESET <= psg_fire;
    end
  end

  // Overflow events fire only when the bit goes from clear to set.
  assign irq_evt[aus_pkg::IRQ_A0_OVF] = next_acc_ovf[0] && !acc_ovf[0];
  assign irq_evt[aus_pkg::IRQ_A1_OVF] = next_acc_ovf[1] && !acc_ovf[1];
  assign irq_evt[aus_pkg::IRQ_PSG]    = psg_fire;

  // A new event in the clearing cycle wins over the write-one clear.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_stat <= aus_pkg::IRQ_RESET;
    end else if (wr_lo && (WB_ADR_I == aus_pkg::ADR_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~WB_DAT_I[aus_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_mask <= aus_pkg::IRQ_RESET;
    end else if (wr_lo && (WB_ADR_I == aus_pkg::ADR_IRQ_MASK)) begin
      irq_mask <= WB_DAT_I[aus_pkg::IRQ_W-1:0];
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

endmodule : aus_ctrl_status

// *** rtl/aus_pkg.sv ***
package aus_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADR_STATUS   = 8'h00;
  localparam logic [7:0] ADR_CONTROL  = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;

  // Status word field positions.
  localparam int ST_MINUS    = 15;
  localparam int ST_EQUAL    = 14;
  localparam int ST_LOG_OVF  = 13;
  localparam int ST_MATH_OVF = 12;
  localparam int ST_A1_OVF   = 9;
  localparam int ST_A1_GUARD = 5;
  localparam int ST_A0_OVF   = 4;
  localparam int ST_A0_GUARD = 0;

  // Clear-inhibit bit positions inside the three-bit field.
  localparam int CLR_Y  = 2;
  localparam int CLR_A1 = 1;
  localparam int CLR_A0 = 0;

  // Interrupt event bit positions.
  localparam int IRQ_A0_OVF = 0;
  localparam int IRQ_A1_OVF = 1;
  localparam int IRQ_PSG    = 2;
  localparam int IRQ_W      = 3;

  localparam logic [8:0]        CTL_RESET = 9'h000;
  localparam logic [IRQ_W-1:0]  IRQ_RESET = 3'h0;
  localparam logic [35:0]       SAT_POS   = 36'h0_7fff_ffff;
  localparam logic [35:0]       SAT_NEG   = 36'hf_8000_0000;

  typedef enum logic [1:0] {
    ALIGN_NONE = 2'b00,
    ALIGN_DIV4 = 2'b01,
    ALIGN_MUL4 = 2'b10,
    ALIGN_MUL2 = 2'b11
  } aus_align_t;

  // Arithmetic control register, laid out at its bit positions 8:0.
  typedef struct packed {
    logic       generator_reset_policy;
    logic       square_mode;
    logic [2:0] clear_inhibit_field;
    logic [1:0] saturation_disable_field;
    aus_align_t align;
  } aus_control_t;

  // Result of an arithmetic or bit manipulation operation.
  typedef struct packed {
    logic        wr;
    logic        acc;
    logic        use_product;
    logic [35:0] value;
    logic        logical_overflow;
    logic        math_overflow;
  } aus_op_t;

  // Plain data move into an accumulator half.
  typedef struct packed {
    logic        wr;
    logic        acc;
    logic        high;
    logic [15:0] data;
  } aus_move_t;

endpackage : aus_pkg

// *** sim/aus_ctrl_status_asserts.sv ***
`timescale 1ns/100ps
module aus_ctrl_status_chk (
  // Watched ports
  input wire logic             CORE_CLK,
  input wire logic             SYS_RST,
  input wire logic [7:0]       WB_ADR_I,
  input wire logic             WB_WE_I,
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic             WB_ACK_O,
  input wire aus_pkg::aus_op_t DAU_OP,
  input wire aus_pkg::aus_op_t BMU_OP,
  input wire logic [15:0]      OPND_DATA,
  input wire logic             X_WR,
  input wire logic             Y_HI_WR,
  input wire logic             Y_LO_WR,
  input wire logic             PI_WR,
  input wire logic             IN_ISR,
  input wire logic             PSG_RESET,
  input wire logic [15:0]      X_OPERAND,
  input wire logic [31:0]      Y_OPERAND,
  input wire logic [35:0]      ACC0_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic req;
  assign req = WB_CYC_I && WB_STB_I;
  // Saturation cannot alter a value whose top five bits agree.
  function automatic logic fits(input logic [35:0] v);
    return &v[35:31] || ~|v[35:31];
  endfunction : fits
  a_ack_next: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_cause: assert property (WB_ACK_O |-> $past(req)) else $error("ack without request");
  a_ctl_upper: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == aus_pkg::ADR_CONTROL
    |-> WB_DAT_O[15:9] == 7'h00) else $error("control upper bits set");
  a_psg_cause: assert property (PSG_RESET |-> $past(PI_WR && !IN_ISR))
    else $error("generator reset without cause");
  a_x_load: assert property (X_WR && !Y_HI_WR |=> X_OPERAND == $past(OPND_DATA))
    else $error("x load wrong");
  a_y_high: assert property (Y_HI_WR |=> Y_OPERAND[31:16] == $past(OPND_DATA))
    else $error("y high load wrong");
  a_y_low: assert property (Y_LO_WR && !Y_HI_WR |=> Y_OPERAND[15:0] == $past(OPND_DATA))
    else $error("y low load wrong");
  a_dau_acc: assert property (DAU_OP.wr && !DAU_OP.acc && !DAU_OP.use_product
    && fits(DAU_OP.value) |-> ##2 ACC0_OUT == $past(DAU_OP.value, 2)) else $error("dau acc");
  a_bmu_acc: assert property (BMU_OP.wr && !DAU_OP.wr && !BMU_OP.acc && fits(BMU_OP.value)
    |-> ##2 ACC0_OUT == $past(BMU_OP.value, 2)) else $error("bmu acc");
  c_psg: cover property (PSG_RESET);
  c_write: cover property (WB_ACK_O && WB_WE_I);
  c_square: cover property (Y_HI_WR ##1 X_OPERAND == Y_OPERAND[31:16]);
endmodule : aus_ctrl_status_chk
bind aus_ctrl_status aus_ctrl_status_chk u_chk (.*);

// *** sim/arith_unit_control_status_test.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module arith_unit_control_status_test;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cs = 1'b0;
  logic               we = 1'b0;
  logic [3:0]         strb = 4'h0;
  logic               isr = 1'b0;
  logic               ack, pseudorandom_generator, irq, i0;
  logic [7:0]         adr = 8'h00;
  logic [15:0]        od = 16'h0000;
  logic [15:0]        xo;
  logic [31:0]        dat = 32'h0, prod = 32'h0, rdo, yo, q;
  logic [35:0]        a0o, a1o, v;
  logic [35:0]        ea [2];
  logic               eo [2];
  aus_pkg::aus_op_t   dop = '0, bop = '0;
  aus_pkg::aus_move_t mov = '0;
  int                 failures = 0, total_checks = 0;
  aus_ctrl_status u_dut (.CORE_CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(4'h3), .WB_WE_I(we), .WB_CYC_I(cs), .WB_STB_I(cs), .WB_DAT_O(rdo),
    .WB_ACK_O(ack), .DAU_OP(dop), .BMU_OP(bop), .PRODUCT(prod), .ACC_MOVE(mov),
    .OPND_DATA(od), .X_WR(strb[0]), .Y_LO_WR(strb[1]), .Y_HI_WR(strb[2]), .PI_WR(strb[3]),
    .IN_ISR(isr), .PSG_RESET(pseudorandom_generator), .X_OPERAND(xo), .Y_OPERAND(yo), .ACC0_OUT(a0o),
    .ACC1_OUT(a1o), .IRQ(irq));
  initial forever #10 clk = ~clk;
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge clk);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    if (ack !== 1'b1) failures++;
    q = rdo;
    cs <= 1'b0;
  endtask : wb
  task automatic op(input logic b, input aus_pkg::aus_op_t o);
    @(posedge clk);
    if (b) bop <= o;
    else dop <= o;
    @(posedge clk);
    dop.wr <= 1'b0;
    bop.wr <= 1'b0;
  endtask : op
  // Strobe bits: 0 x load, 1 y low, 2 y high, 3 interrupt register write.
  task automatic pulse(input logic [3:0] k, input logic [15:0] d);
    @(posedge clk);
    od <= d;
    strb <= k;
    @(posedge clk);
    strb <= 4'h0;
  endtask : pulse
  task automatic mv(input logic hi, input logic [15:0] d);
    @(posedge clk);
    mov <= '{1'b1, 1'b0, hi, d};
    @(posedge clk);
    mov.wr <= 1'b0;
  endtask : mv
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle
  function automatic logic [35:0] aligned(input logic [31:0] p, input logic [1:0] c);
    logic [35:0] s;
    s = {{4{p[31]}}, p};
    case (c)
      2'b00: return s;
      2'b01: return $signed(s) >>> 2;
      2'b10: return s << 2;
      default: return s << 1;
    endcase
  endfunction : aligned
  function automatic logic [15:0] status(input logic [35:0] r, input logic l, input logic m);
    return {r[35], r == 36'h0, l, m, 2'b00, eo[1], ea[1][35:32], eo[0], ea[0][35:32]};
  endfunction : status
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    logic l, m, c;
    void'($urandom(19));
    ea[1] = 36'h0_0000_0000;
    eo[1] = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(0, aus_pkg::ADR_CONTROL, 0);
    `CHK(q, 32'h0)
    wb(0, 8'h10, 0);
    `CHK(q, 32'h0)
    wb(1, aus_pkg::ADR_CONTROL, 16'hffff);
    wb(0, aus_pkg::ADR_CONTROL, 0);
    `CHK(q, 32'h1ff)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      prod <= (k == 2) ? 32'h8000_0001 : $urandom;
      wb(1, aus_pkg::ADR_CONTROL, 16'h000c | 16'(k));
      op(0, '{1'b1, 1'b0, 1'b1, 36'h0, 1'b0, 1'b0});
      settle();
      ea[0] = aligned(prod, k[1:0]);
      eo[0] = 1'b0;
      `CHK(a0o, ea[0])
    end
    $display("test align done");
    for (int i = 0; i < 12; i++) begin
      v = 36'({$urandom, $urandom});
      v = (i == 0) ? 36'h8_0000_0000 : (i == 1) ? 36'h0 : (i == 2) ? 36'h1234 : v;
      c = (i < 4) ? 1'b0 : 1'($urandom);
      l = 1'($urandom);
      m = 1'($urandom);
      op(i[0], '{1'b1, c, 1'b0, v, l, m});
      ea[c] = v;
      eo[c] = m;
      wb(0, aus_pkg::ADR_STATUS, 0);
      `CHK(q, {16'h0, status(v, l, m)})
    end
    mv(1'b0, 16'($urandom));
    wb(0, aus_pkg::ADR_STATUS, 0);
    `CHK(q[15:12], {v[35], v == 36'h0, l, m})
    $display("test flags done");
    wb(1, aus_pkg::ADR_CONTROL, 16'h0008);
    op(0, '{1'b1, 1'b0, 1'b0, 36'h1_0000_0000, 1'b0, 1'b1});
    op(0, '{1'b1, 1'b1, 1'b0, 36'h1_0000_0000, 1'b0, 1'b1});
    settle();
    `CHK(a0o, aus_pkg::SAT_POS)
    `CHK(a1o, 36'h1_0000_0000)
    op(0, '{1'b1, 1'b0, 1'b0, 36'he_0000_0000, 1'b0, 1'b1});
    settle();
    `CHK(a0o, aus_pkg::SAT_NEG)
    wb(0, aus_pkg::ADR_IRQ_STAT, 0);
    `CHK(q, 32'h3)
    wb(1, aus_pkg::ADR_STATUS, 16'h93a5);
    wb(0, aus_pkg::ADR_STATUS, 0);
    `CHK(q, 32'h93a5)
    $display("test saturation done");
    for (int k = 0; k < 2; k++) begin
      wb(1, aus_pkg::ADR_CONTROL, k ? 16'h00d0 : 16'h0000);
      pulse(4'h1, 16'h5a5a);
      pulse(4'h2, 16'h1234);
      mv(1'b0, 16'h1111);
      pulse(4'h4, 16'habcd);
      mv(1'b1, 16'h2222);
      settle();
      `CHK(yo, {16'habcd, k ? 16'h1234 : 16'h0})
      `CHK(a0o, {20'h02222, k ? 16'h1111 : 16'h0})
      `CHK(xo === 16'habcd, k[0])
    end
    $display("test clearing done");
    wb(1, aus_pkg::ADR_IRQ_STAT, 16'h0007);
    for (int k = 0; k < 4; k++) begin
      wb(1, aus_pkg::ADR_CONTROL, {7'h0, k[1], 8'h0});
      isr <= k[0];
      pulse(4'h8, 16'h0);
      #1;
      `CHK(pseudorandom_generator, ~k[1] & ~k[0])
    end
    $display("test generator done");
    wb(0, aus_pkg::ADR_IRQ_STAT, 0);
    `CHK(q, 32'h4)
    wb(1, aus_pkg::ADR_IRQ_MASK, 16'h0000);
    settle();
    i0 = irq;
    wb(1, aus_pkg::ADR_IRQ_MASK, 16'h0007);
    settle();
    `CHK(i0 ^ irq, 1'b1)
    wb(1, aus_pkg::ADR_IRQ_STAT, 16'h0007);
    settle();
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    end_of_test();
  end
endmodule : arith_unit_control_status_test
